// ==== hw/lgc_consts.vh ====
// Purpose: constants of the low-side gate channel control block
// Assumes: 100 MHz logic clock, 16-bit serial frames, six channels
// Notes:   times are given in their own unit, cycle counts derive from them
//
// What this block does
// RQ1: six independent channels, each with control, fault path and configuration store
// RQ2: gate high only while reset inactive and no battery short latched
// RQ3: gate request is channel pin input OR serial gate bit
// RQ4: serial gate bits read zero after power-on and after reset
// RQ5: host keeps the unused source of each channel low
// RQ6: one output control write updates all serial gate bits together
// RQ7: serial input sampled on rising serial clock while select low
// RQ8: serial output changes on falling serial clock, shifting fault data
// RQ9: while select low, serial output driven and input accepted
// RQ10: while select high, output tristated, serial input and clock ignored
// RQ11: shifted word written to its register only on select rising edge
// RQ12: host reads back latched fault status of every channel
// RQ13: qualified reset returns registers to power-on values, forces gates low
// RQ14: qualified reset clears faults and fault bits, sets logic reset flag
// RQ15: after reset undervoltage and overtemp flags show live detector outputs
// RQ16: reset glitch filter ignores low pulses shorter than glitch time
// RQ17: per-channel fault mask ignores detector output, any combination
// RQ18: per channel: one of two ground and eight battery short thresholds
// RQ19: per channel: one of four on and four off blank times
// RQ20: one shared retry timer serves automatic re-enable after battery shorts; the code keeps one shared timer per retry period select
// RQ21: gate on monitors battery short; gate off enables bias, checks ground/open
// RQ22: battery short threshold select sits in configuration bits 1 to 3
// RQ23: on-state blank select sits in configuration bits 4 and 5
// RQ24: with retry enabled, tripped channel stays off until retry expiry
// RQ25: fault detection disabled while reset low or channel masked
// RQ26: pin inputs and reset synchronised to the logic clock before use
// RQ27: reset pulse width and glitch time counted as clock cycles low
`ifndef LGC_CONSTS_VH
`define LGC_CONSTS_VH

`define LGC_N_CH          6
`define LGC_FRAME_BITS    16
`define LGC_CFG_BITS      12
// frame layout: address in the top nibble, data below
`define LGC_ADDR_HI       15
`define LGC_ADDR_LO       12
`define LGC_A_OUTCTL      4'h0
`define LGC_A_MASK        4'h1
`define LGC_A_CFG0        4'h2
`define LGC_A_FR1         4'h8
// configuration register fields
`define LGC_CF_STG        0
`define LGC_CF_SB_LO      1
`define LGC_CF_SB_HI      3
`define LGC_CF_TON_LO     4
`define LGC_CF_TON_HI     5
`define LGC_CF_TOF_LO     6
`define LGC_CF_TOF_HI     7
`define LGC_CF_RT0        10
`define LGC_CF_RT1        11

`define LGC_CLK_NS        10
`define LGC_BLANK_ON0_US  5
`define LGC_BLANK_ON1_US  14
`define LGC_BLANK_ON2_US  28
`define LGC_BLANK_ON3_US  56
`define LGC_BLANK_OFF0_US 80
`define LGC_BLANK_OFF1_US 140
`define LGC_BLANK_OFF2_US 280
`define LGC_BLANK_OFF3_US 4000
`define LGC_FILTER_NS     2000
`define LGC_RETRY_S_MS    10
`define LGC_RETRY_L_MS    55
`define LGC_RGF_NS        1000
`define LGC_RST_MIN_NS    5000

`define LGC_US2CYC(t)     ((t) * 1000 / `LGC_CLK_NS)
`define LGC_MS2CYC(t)     ((t) * 1000000 / `LGC_CLK_NS)
`define LGC_FILTER_CYC    ((`LGC_FILTER_NS + `LGC_CLK_NS - 1) / `LGC_CLK_NS)
`define LGC_RGF_CYC       ((`LGC_RGF_NS + `LGC_CLK_NS - 1) / `LGC_CLK_NS)
`define LGC_RST_MIN_CYC   ((`LGC_RST_MIN_NS + `LGC_CLK_NS - 1) / `LGC_CLK_NS)

`endif

// ==== hw/lgc_sync.v ====
// Purpose: two-flop synchroniser for a group of asynchronous levels
// Assumes: each bit is an independent level
// Notes:   stage one is read only by stage two
`timescale 1ns/100ps
module lgc_sync #(
  parameter W = 1
) (
  input  wire         clk, // sampling clock
  input  wire [W-1:0] d,   // asynchronous levels
  output reg  [W-1:0] q    // synchronised levels
);
  reg [W-1:0] meta;

  // plain double flop; no reset so the chain settles on its own
  always @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end
endmodule // lgc_sync

// ==== hw/lgc_channel_ctrl.v ====
// Purpose: six-channel low-side gate control with serial slave port
// Assumes: serial clock idles low, frames are 16 bits, msb first
// Notes:   analog comparators and bias sources live outside this block
`timescale 1ns/100ps
`include "lgc_consts.vh"
module lgc_channel_ctrl #(
  parameter N_CH    = `LGC_N_CH,
  parameter BLK_ON0 = `LGC_US2CYC(`LGC_BLANK_ON0_US),
  parameter BLK_ON1 = `LGC_US2CYC(`LGC_BLANK_ON1_US),
  parameter BLK_ON2 = `LGC_US2CYC(`LGC_BLANK_ON2_US),
  parameter BLK_ON3 = `LGC_US2CYC(`LGC_BLANK_ON3_US),
  parameter BLK_OF0 = `LGC_US2CYC(`LGC_BLANK_OFF0_US),
  parameter BLK_OF1 = `LGC_US2CYC(`LGC_BLANK_OFF1_US),
  parameter BLK_OF2 = `LGC_US2CYC(`LGC_BLANK_OFF2_US),
  parameter BLK_OF3 = `LGC_US2CYC(`LGC_BLANK_OFF3_US),
  parameter FILT    = `LGC_FILTER_CYC,
  parameter RETRY_S = `LGC_MS2CYC(`LGC_RETRY_S_MS),
  parameter RETRY_L = `LGC_MS2CYC(`LGC_RETRY_L_MS),
  parameter RGF_CYC = `LGC_RGF_CYC,
  parameter RST_MIN = `LGC_RST_MIN_CYC
) (
  input  wire              ref_clk,            // logic clock, 100 MHz
  input  wire              reset,              // power-on reset, sync, high
  input  wire              reset_low_in,       // reset pin, active low
  input  wire [N_CH-1:0]   channel_pin_input,  // parallel gate requests
  input  wire [N_CH-1:0]   stb_detect,         // battery short comparators
  input  wire [N_CH-1:0]   stg_detect,         // ground short comparators
  input  wire [N_CH-1:0]   open_detect,        // open load comparators
  input  wire              uv_detect,          // undervoltage detector
  input  wire              ot_detect,          // overtemperature detector
  input  wire              spi_sck,            // serial clock
  input  wire              spi_cs_n,           // chip select, active low
  input  wire              spi_sdi,            // serial data in
  output reg               spi_sdo,            // serial data out
  output wire              spi_sdo_oe_n,       // low while sdo is driven
  output wire [N_CH-1:0]   gate_drive_out,     // gate requests to drivers
  output wire [N_CH-1:0]   diag_bias_en,       // off-state bias enables
  output wire [N_CH-1:0]   stg_thr_sel,        // ground threshold selects
  output wire [3*N_CH-1:0] battery_short_threshold_sel // 3 bits per channel
);
  localparam FB = `LGC_FRAME_BITS;
  localparam CB = `LGC_CFG_BITS;
  localparam [18:0] FILT_M1 = FILT - 1;
  localparam [18:0] FILT_C  = FILT;
  localparam [22:0] RS_M1   = RETRY_S - 1;
  localparam [22:0] RL_M1   = RETRY_L - 1;
  localparam [15:0] RGF_C   = RGF_CYC;
  localparam [15:0] RST_C   = RST_MIN;

  // RQ26 synchronise pins
  wire [5:0]      ctl_s;
  wire [N_CH-1:0] pin_s;
  wire [N_CH-1:0] stb_s;
  wire [N_CH-1:0] stg_s;
  wire [N_CH-1:0] ol_s;
  lgc_sync #(.W(6)) u_sync_ctl (
    .clk (ref_clk),
    .d   ({reset_low_in, spi_sck, spi_cs_n, spi_sdi, uv_detect, ot_detect}),
    .q   (ctl_s)
  );
  lgc_sync #(.W(N_CH)) u_sync_pin (
    .clk (ref_clk),
    .d   (channel_pin_input),
    .q   (pin_s)
  );
  lgc_sync #(.W(3*N_CH)) u_sync_det (
    .clk (ref_clk),
    .d   ({stb_detect, stg_detect, open_detect}),
    .q   ({stb_s, stg_s, ol_s})
  );
  wire rpin_s = ctl_s[5];
  wire sck_s  = ctl_s[4];
  wire cs_s   = ctl_s[3];
  wire sdi_s  = ctl_s[2];
  wire uv_s   = ctl_s[1];
  wire ot_s   = ctl_s[0];

  // reset pin filter: low-time counter saturating at the qualify count
  reg  [15:0] rlo_cnt;
  wire        rst_act;
  wire        rst_qual;
  wire        clr;
  // RQ27 count low cycles
  always @(posedge ref_clk) begin
    if (reset || rpin_s) begin
      rlo_cnt <= 16'h0000;
    end else if (rlo_cnt != RST_C) begin
      rlo_cnt <= rlo_cnt + 16'h0001;
    end
  end
  // RQ16 ignore short glitches
  assign rst_act  = (rlo_cnt >= RGF_C);
  // RQ13 qualified reset level
  assign rst_qual = (rlo_cnt == RST_C);
  assign clr      = reset | rst_qual;

  // serial edge detection on synchronised copies of the pins
  reg  sck_d;
  reg  cs_d;
  always @(posedge ref_clk) begin
    sck_d <= sck_s;
    cs_d  <= cs_s;
  end
  // RQ10 clock ignored while deselected
  wire sck_rise = sck_s & ~sck_d & ~cs_s;
  wire sck_fall = ~sck_s & sck_d & ~cs_s;
  wire cs_fall  = cs_d & ~cs_s;
  wire cs_rise  = ~cs_d & cs_s;
  // RQ9 drive sdo only while selected
  assign spi_sdo_oe_n = cs_s;

  reg  [FB-1:0]   sh_in;
  reg  [FB-1:0]   sh_out;
  reg  [4:0]      bit_cnt;
  reg             fr1_sel;
  reg  [N_CH-1:0] gbit;
  reg  [N_CH-1:0] mask;
  reg  [CB-1:0]   cfg [0:N_CH-1];
  reg  [N_CH-1:0] f_stb;
  reg  [N_CH-1:0] f_stg;
  reg  [N_CH-1:0] f_ol;
  reg             lr;
  wire [N_CH-1:0] stb_l;
  wire [N_CH-1:0] stg_l;
  wire [N_CH-1:0] ol_l;
  wire [N_CH-1:0] wait_rt;
  wire [N_CH-1:0] rt0v;
  wire [3:0]      waddr = sh_in[`LGC_ADDR_HI:`LGC_ADDR_LO];
  wire [CB-1:0]   wdata = sh_in[CB-1:0];
  // RQ11 commit only on select rising edge with a full frame
  wire            commit = cs_rise & (bit_cnt == FB[4:0]) & ~rst_act;
  wire            wr_g   = commit & (waddr == `LGC_A_OUTCTL);
  // RQ12 two fault words, the second picked by the previous frame
  wire [FB-1:0]   fr0 = {lr, uv_s, ot_s, 1'b0, f_stg, f_stb};
  wire [FB-1:0]   fr1 = {10'h000, f_ol};
  wire [FB-1:0]   reply = fr1_sel ? fr1 : fr0;
  integer k;

  // shift engine
  always @(posedge ref_clk) begin
    if (reset) begin
      sh_in   <= 16'h0000;
      sh_out  <= 16'h0000;
      bit_cnt <= 5'h00;
      spi_sdo <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt <= 5'h00;
      sh_out  <= {reply[FB-2:0], 1'b0};
      spi_sdo <= reply[FB-1];
    end else begin
      // RQ7 sample sdi on rising sck
      if (sck_rise) begin
        sh_in <= {sh_in[FB-2:0], sdi_s};
        if (bit_cnt != 5'h1f) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
      // RQ8 shift fault data out on falling sck
      if (sck_fall) begin
        spi_sdo <= sh_out[FB-1];
        sh_out  <= {sh_out[FB-2:0], 1'b0};
      end
    end
  end

  // register file; qualified reset restores power-on values
  always @(posedge ref_clk) begin
    // RQ4 RQ13 clear gate bits and config
    if (clr) begin
      gbit    <= {N_CH{1'b0}};
      mask    <= {N_CH{1'b0}};
      fr1_sel <= 1'b0;
      for (k = 0; k < N_CH; k = k + 1) begin
        cfg[k] <= 12'h000;
      end
    end else if (commit) begin
      fr1_sel <= (waddr == `LGC_A_FR1);
      // RQ6 all gate bits in one write
      if (wr_g) begin
        gbit <= wdata[N_CH-1:0];
      end
      // RQ17 per-channel mask bits
      if (waddr == `LGC_A_MASK) begin
        mask <= wdata[N_CH-1:0];
      end
      // RQ18 RQ19 per-channel config words
      for (k = 0; k < N_CH; k = k + 1) begin
        if (waddr == (`LGC_A_CFG0 + k[3:0])) begin
          cfg[k] <= wdata;
        end
      end
    end
  end

  // fault report bits: set wins over the clear of a finished transfer
  always @(posedge ref_clk) begin
    // RQ14 clear faults, set logic reset flag
    if (clr) begin
      f_stb <= {N_CH{1'b0}};
      f_stg <= {N_CH{1'b0}};
      f_ol  <= {N_CH{1'b0}};
      lr    <= 1'b1;
    end else begin
      f_stb <= stb_l | (f_stb & {N_CH{~cs_rise}});
      f_stg <= stg_l | (f_stg & {N_CH{~cs_rise}});
      f_ol  <= ol_l | (f_ol & {N_CH{~cs_rise}});
      lr    <= lr & ~cs_rise;
    end
  end
  // RQ15 flags in fr0 read live detector levels, never cleared

  // RQ20 shared retry timers, one per period select
  reg  [22:0] rt_s_cnt;
  reg  [22:0] rt_l_cnt;
  wire        any_s  = |(wait_rt & ~rt0v);
  wire        any_l  = |(wait_rt & rt0v);
  wire        tick_s = any_s & (rt_s_cnt == RS_M1);
  wire        tick_l = any_l & (rt_l_cnt == RL_M1);
  // a late joiner may see a short first wait; accepted to share the timer
  always @(posedge ref_clk) begin
    if (clr || !any_s || tick_s) begin
      rt_s_cnt <= 23'h00_0000;
    end else begin
      rt_s_cnt <= rt_s_cnt + 23'h00_0001;
    end
    if (clr || !any_l || tick_l) begin
      rt_l_cnt <= 23'h00_0000;
    end else begin
      rt_l_cnt <= rt_l_cnt + 23'h00_0001;
    end
  end

  // RQ1 one copy of the channel logic per output
  genvar i;
  generate
    for (i = 0; i < N_CH; i = i + 1) begin : g_ch
      wire [CB-1:0] c    = cfg[i];
      wire          cmd  = pin_s[i] | gbit[i];
      // RQ25 detection off in reset or mask
      wire          den  = ~rst_act & ~mask[i];
      reg           on_q;
      reg           stb_q;
      reg           stg_q;
      reg           ol_q;
      reg           bias;
      reg  [18:0]   blk;
      reg  [18:0]   flt;
      reg  [18:0]   blk_load;
      // RQ2 RQ3 RQ24 gate request
      wire          nxt  = cmd & ~rst_act & ~stb_q;
      wire          chg  = (nxt != on_q);
      wire          hit_on  = on_q & stb_s[i];
      wire          hit_off = ~on_q & (stg_s[i] | ol_s[i]);
      wire          cond = den & ~chg & (blk == 19'h0_0000) & (hit_on | hit_off);
      wire          trip = cond & (flt == FILT_M1);
      wire          rt_tick = c[`LGC_CF_RT0] ? tick_l : tick_s;

      // RQ19 RQ23 blank time pick by gate direction
      always @* begin
        blk_load = 19'h0_0000;
        case ({nxt, nxt ? c[`LGC_CF_TON_HI:`LGC_CF_TON_LO]
                        : c[`LGC_CF_TOF_HI:`LGC_CF_TOF_LO]})
          3'h4:    blk_load = BLK_ON0[18:0];
          3'h5:    blk_load = BLK_ON1[18:0];
          3'h6:    blk_load = BLK_ON2[18:0];
          3'h7:    blk_load = BLK_ON3[18:0];
          3'h0:    blk_load = BLK_OF0[18:0];
          3'h1:    blk_load = BLK_OF1[18:0];
          3'h2:    blk_load = BLK_OF2[18:0];
          3'h3:    blk_load = BLK_OF3[18:0];
          default: blk_load = 19'h0_0000;
        endcase
      end

      always @(posedge ref_clk) begin
        if (clr) begin
          on_q  <= 1'b0;
          bias  <= 1'b0;
          blk   <= 19'h0_0000;
          flt   <= 19'h0_0000;
          stb_q <= 1'b0;
          stg_q <= 1'b0;
          ol_q  <= 1'b0;
        end else begin
          on_q <= nxt;
          // RQ21 bias on while gate off and detection enabled
          bias <= ~nxt & den;
          // blank counter restarts on every gate edge
          if (chg) begin
            blk <= blk_load;
          end else if (blk != 19'h0_0000) begin
            blk <= blk - 19'h0_0001;
          end
          // filter: detector must stay set FILT cycles after blanking
          if (!cond) begin
            flt <= 19'h0_0000;
          end else if (flt != FILT_C) begin
            flt <= flt + 19'h0_0001;
          end
          // off-state latches drop at the end of a clean off blank
          if (~on_q && ~chg && blk == 19'h0_0001) begin
            if (!stg_s[i]) begin
              stg_q <= 1'b0;
            end
            if (!ol_s[i]) begin
              ol_q <= 1'b0;
            end
          end
          // serial gate bit written zero or retry expiry releases a battery short
          if ((wr_g && !wdata[i]) || (stb_q && c[`LGC_CF_RT1] && rt_tick)) begin
            stb_q <= 1'b0;
          end
          // RQ21 on-state battery check, off-state ground and open
          if (trip && on_q) begin
            stb_q <= 1'b1;
          end
          if (trip && !on_q) begin
            stg_q <= stg_q | stg_s[i];
            ol_q  <= ol_q | ol_s[i];
          end
        end
      end

      assign gate_drive_out[i] = on_q;
      assign diag_bias_en[i]   = bias;
      assign stb_l[i]          = stb_q;
      assign stg_l[i]          = stg_q;
      assign ol_l[i]           = ol_q;
      // RQ24 retry wait holds gate off
      assign wait_rt[i]        = stb_q & c[`LGC_CF_RT1];
      assign rt0v[i]           = c[`LGC_CF_RT0];
      // RQ18 RQ22 threshold selects out to analog
      assign stg_thr_sel[i]    = c[`LGC_CF_STG];
      assign battery_short_threshold_sel[3*i+2:3*i] = c[`LGC_CF_SB_HI:`LGC_CF_SB_LO];
    end
  endgenerate
endmodule // lgc_channel_ctrl

// ==== tb/lgc_channel_ctrl_properties.sv ====
// Purpose: port-level checks of the gate channel control block
// Assumes: pin reset filter of RGF_CYC cycles, below 250
// Notes:   margins cover the two-flop input synchronisers
`timescale 1ns/100ps
module lgc_ctl_props #(
  parameter N_CH    = 6,
  parameter RGF_CYC = 100
) (
  input wire              ref_clk,                    // logic clock
  input wire              reset,                      // sync reset
  input wire              reset_low_in,               // reset pin
  input wire              spi_sck,                    // serial clock
  input wire              spi_cs_n,                   // chip select
  input wire              spi_sdo,                    // serial out
  input wire              spi_sdo_oe_n,               // sdo enable
  input wire [N_CH-1:0]   gate_drive_out,             // gates
  input wire [N_CH-1:0]   diag_bias_en,               // bias enables
  input wire [N_CH-1:0]   stg_thr_sel,                // ground selects
  input wire [3*N_CH-1:0] battery_short_threshold_sel // battery selects
);
  reg [7:0] low_cnt; // cycles the pin reset has been low
  // saturating run length, so a long hold stays counted
  always @(posedge ref_clk) begin
    if (reset || reset_low_in)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hff)
      low_cnt <= low_cnt + 8'h01;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_oe_off; spi_cs_n [*4] |-> spi_sdo_oe_n; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("sdo driven with select high");
  property p_oe_on; !spi_cs_n [*4] |-> !spi_sdo_oe_n; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("sdo not driven with select low");
  property p_sdo_fall; $changed(spi_sdo) |-> !$past(spi_sck, 3); endproperty
  a_sdo_fall: assert property (p_sdo_fall)
    else $error("sdo moved outside a clock low phase");
  property p_cfg_cs;
    $changed({stg_thr_sel, battery_short_threshold_sel}) |-> spi_cs_n && $past(spi_cs_n, 2);
  endproperty
  a_cfg_cs: assert property (p_cfg_cs)
    else $error("configuration changed inside a frame");
  property p_gate_rst; low_cnt > RGF_CYC + 4 |-> gate_drive_out == 0; endproperty
  a_gate_rst: assert property (p_gate_rst)
    else $error("gate on while pin reset held low");
  property p_gate_rise;
    (gate_drive_out & ~$past(gate_drive_out)) != 0 |-> $past(reset_low_in, 3);
  endproperty
  a_gate_rise: assert property (p_gate_rise)
    else $error("gate rose under pin reset");
  property p_bias; $stable(gate_drive_out) [*4] |-> (gate_drive_out & diag_bias_en) == 0;
  endproperty
  a_bias: assert property (p_bias)
    else $error("bias enabled on a driven channel");
  property p_rst_out;
    $fell(reset) |-> gate_drive_out == 0 && stg_thr_sel == 0 && battery_short_threshold_sel == 0;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not cleared by reset");
endmodule // lgc_ctl_props

bind lgc_channel_ctrl lgc_ctl_props #(.N_CH(N_CH), .RGF_CYC(RGF_CYC)) u_props (
  .ref_clk, .reset, .reset_low_in, .spi_sck, .spi_cs_n, .spi_sdo, .spi_sdo_oe_n,
  .gate_drive_out, .diag_bias_en, .stg_thr_sel, .battery_short_threshold_sel);

// ==== tb/lgc_host_model.sv ====
// Purpose: host side of the serial port, frames sent bit by bit
// Assumes: serial clock idles low, 40 ns half periods
// Notes:   lines sit at their pull levels between frames
`timescale 1ns/100ps
module lgc_host_model (
  input  wire ref_clk,  // paces the serial timing
  input  wire spi_sdo,  // reply wire, z while released
  output reg  spi_sck,  // serial clock, idles low, also toggled with select high
  output reg  spi_cs_n, // chip select, pulled up when idle
  output reg  spi_sdi   // data out, pulled down when idle
);
  // idle levels from time zero
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // one half period of the serial clock
  task half;
    repeat (4) @(negedge ref_clk);
  endtask
  task xfer(input integer nbits, input [15:0] w, output [15:0] r);
    integer i;
    begin
      r = 16'h0000;
      spi_cs_n = 1'b0;
      half;
      for (i = nbits - 1; i >= 0; i = i - 1) begin
        spi_sdi = w[i];
        half;
        r = {r[14:0], spi_sdo};
        spi_sck = 1'b1;
        half;
        spi_sck = 1'b0;
      end
      half;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
      repeat (14) @(negedge ref_clk);
    end
  endtask
  // clocking with select high, pattern of a gate write
  task noise;
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        spi_sdi = (i >= 10);
        half;
        spi_sck = 1'b1;
        half;
        spi_sck = 1'b0;
      end
      spi_sdi = 1'b0;
    end
  endtask
endmodule // lgc_host_model

// ==== tb/lgc_channel_ctrl_test.sv ====
// Purpose: self-checking bench of the gate channel control block
// Assumes: shortened first blank times, filter and short retry; reset counts as built
// Notes:   inputs move on the falling clock edge only
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, g); err_count++; end end
module lgc_channel_ctrl_test;
  reg         ref_clk;
  reg         reset;
  reg         reset_low_in;
  reg  [5:0]  channel_pin_input;
  reg  [5:0]  stb_detect;
  reg  [5:0]  stg_detect;
  reg  [5:0]  open_detect;
  reg         uv_detect;
  reg         ot_detect;
  wire        spi_sck;
  wire        spi_cs_n;
  wire        spi_sdi;
  wire        spi_sdo;
  wire        spi_sdo_oe_n;
  wire        sdo_wire;
  wire [5:0]  gate_drive_out;
  wire [5:0]  diag_bias_en;
  wire [5:0]  stg_thr_sel;
  wire [17:0] battery_short_threshold_sel;
  integer     err_count;
  integer     cmp_count;
  integer     cyc;
  reg  [15:0] rd;
  // released reply wire floats, so a read outside a frame shows z
  assign sdo_wire = spi_sdo_oe_n ? 1'bz : spi_sdo;
  // only what the scenarios wait on is shortened; the reset filter keeps its own counts
  lgc_channel_ctrl #(.BLK_ON0(20), .BLK_OF0(20), .FILT(8), .RETRY_S(300)) DUT (
    .ref_clk, .reset, .reset_low_in, .channel_pin_input, .stb_detect, .stg_detect,
    .open_detect, .uv_detect, .ot_detect, .spi_sck, .spi_cs_n, .spi_sdi, .spi_sdo,
    .spi_sdo_oe_n, .gate_drive_out, .diag_bias_en, .stg_thr_sel,
    .battery_short_threshold_sel);
  lgc_host_model host (.ref_clk, .spi_sdo(sdo_wire), .spi_sck, .spi_cs_n, .spi_sdi);
  // 100 MHz logic clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim;
    end
  end
  task wt(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  task end_sim;
    begin
      if (err_count == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task t_flags;
    begin
      uv_detect = 1'b1;
      wt(4);
      host.xfer(16, 16'h0000, rd);
      `CHK("reply after reset", 16'hc000, rd)
      `CHK("sdo released", 1'b1, spi_sdo_oe_n)
      ot_detect = 1'b1;
      uv_detect = 1'b0;
      wt(4);
      host.xfer(16, 16'h0000, rd);
      `CHK("live flags", 16'h2000, rd)
      ot_detect = 1'b0;
      `CHK("gates idle", 6'h00, gate_drive_out)
    end
  endtask
  task t_gates;
    begin
      channel_pin_input = 6'h03;
      wt(6);
      `CHK("pin gates", 6'h03, gate_drive_out)
      host.xfer(16, 16'h0030, rd);
      `CHK("or gates", 6'h33, gate_drive_out)
      `CHK("bias off-state", 6'h0c, diag_bias_en)
      host.xfer(16, 16'h000c, rd);
      `CHK("one write", 6'h0f, gate_drive_out)
      host.xfer(15, 16'h003f, rd);
      `CHK("short frame", 6'h0f, gate_drive_out)
      host.noise;
      wt(8);
      `CHK("select high", 6'h0f, gate_drive_out)
      channel_pin_input = 6'h00;
      host.xfer(16, 16'h0000, rd);
      `CHK("gates off", 6'h00, gate_drive_out)
    end
  endtask
  task t_cfg;
    integer p, c, k;
    begin
      for (p = 0; p < 2; p = p + 1) begin
        for (c = 0; c < 6; c = c + 1) begin
          k = (c + 6 * p) % 8;
          host.xfer(16, {4'h2 + c[3:0], 8'h03, k[2:0], c[0]}, rd);
          `CHK("ground sel", c[0], stg_thr_sel[c])
          `CHK("battery sel", k[2:0], battery_short_threshold_sel[3*c+:3])
        end
      end
      `CHK("all channels", 18'h1_a23e, battery_short_threshold_sel)
      `CHK("all grounds", 6'h2a, stg_thr_sel)
    end
  endtask
  task t_faults;
    integer i;
    begin
      host.xfer(16, 16'h2000, rd); // ch0 short blank, latch mode
      host.xfer(16, 16'h1002, rd); // ch1 masked
      stg_detect = 6'h08;
      open_detect = 6'h10;
      stb_detect = 6'h03;
      channel_pin_input = 6'h03;
      wt(100);
      `CHK("battery trip", 6'h02, gate_drive_out)
      host.xfer(16, 16'h8000, rd);
      `CHK("fault word", 16'h0201, rd)
      host.xfer(16, 16'hf000, rd);
      `CHK("open word", 16'h0010, rd)
      host.xfer(16, 16'h2800, rd); // ch0 retry, short period
      host.xfer(16, 16'h0000, rd); // release the latch
      wt(40);
      stb_detect = 6'h00;
      wt(40);
      `CHK("held off", 1'b0, gate_drive_out[0])
      i = 0;
      while (gate_drive_out[0] !== 1'b1 && i < 800) begin
        wt(1);
        i = i + 1;
      end
      `CHK("retried", 1'b1, gate_drive_out[0])
      channel_pin_input = 6'h00;
      stg_detect = 6'h00;
      open_detect = 6'h00;
    end
  endtask
  task t_pin_rst;
    integer i, drops;
    begin
      host.xfer(16, 16'h003f, rd);
      drops = 0;
      // a glitch just under the filter time must not touch the gates
      reset_low_in = 1'b0;
      wt(90);
      reset_low_in = 1'b1;
      for (i = 0; i < 30; i = i + 1) begin
        wt(1);
        if (gate_drive_out !== 6'h3f)
          drops = drops + 1;
      end
      `CHK("glitch ignored", 0, drops)
      reset_low_in = 1'b0;
      wt(520);
      `CHK("reset gates", 6'h00, gate_drive_out)
      `CHK("bias off in reset", 6'h00, diag_bias_en)
      reset_low_in = 1'b1;
      wt(8);
      `CHK("gate bits cleared", 6'h00, gate_drive_out)
      `CHK("cfg cleared", 18'h0_0000, battery_short_threshold_sel)
      host.xfer(16, 16'h0000, rd);
      `CHK("faults cleared", 16'h8000, rd)
    end
  endtask
  // main sequence
  initial begin
    err_count = 0;
    cmp_count = 0;
    cyc = 0;
    reset = 1'b1;
    reset_low_in = 1'b1;
    channel_pin_input = 6'h00;
    stb_detect = 6'h00;
    stg_detect = 6'h00;
    open_detect = 6'h00;
    uv_detect = 1'b0;
    ot_detect = 1'b0;
    wt(4);
    reset = 1'b0;
    wt(4);
    t_flags;
    t_gates;
    t_cfg;
    t_faults;
    t_pin_rst;
    end_sim;
  end
endmodule // lgc_channel_ctrl_test
